// file: core/adc_output_demux_decimator.sv
// output stage: rate divide, demultiplex, mirror and output data clock
`timescale 1ns/1ps
module adc_output_demux_decimator import adc_out_pkg::*; #(
   parameter int LATENCY = PIPE_LATENCY_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [SAMPLE_W-1:0] sampleIn,
   input wire logic rateDivide,
   input wire logic divideFiveSelect,
   input wire logic mirrorOutputs,
   output logic [SAMPLE_W-1:0] primaryOutputPort,
   output logic [SAMPLE_W-1:0] secondaryOutputPort,
   output logic outputDataClock,
   output logic secondaryActive,
   output logic modeLocked
);
   initial begin
      if (LATENCY < 1 || LATENCY > 64) begin
         $error("latency must be between 1 and 64");
      end
   end

   function automatic logic [2:0] modeDivisor(input logic div, input logic five);
      if (!div) begin
         return DIVISOR_ONE;
      end
      return five ? DIVISOR_FIVE : DIVISOR_TWO;
   endfunction

   // switch inputs come from pins: two-stage synchroniser
   logic [2:0] selMeta_q, selMeta_d;
   logic [2:0] selSync_q, selSync_d;

   always_comb begin
      selMeta_d = {mirrorOutputs, divideFiveSelect, rateDivide};
      selSync_d = selMeta_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         selMeta_q <= 3'h0;
         selSync_q <= 3'h0;
      end else begin
         selMeta_q <= selMeta_d;
         selSync_q <= selSync_d;
      end
   end

   // sample taken on the falling clock edge, then delayed by the pipeline
   logic [SAMPLE_W-1:0] fallSample_q, fallSample_d;
   logic [SAMPLE_W-1:0] dly;

   always_comb begin
      fallSample_d = sampleIn;
   end

   always_ff @(negedge sys_clk) begin
      if (rst) begin
         fallSample_q <= SAMPLE_RESET;
      end else begin
         fallSample_q <= fallSample_d;
      end
   end

   sample_delay_line #(
      .WIDTH(SAMPLE_W),
      .DEPTH(LATENCY)
   ) u_delay (
      .clk(sys_clk),
      .rst(rst),
      .dataIn(fallSample_q),
      .dataOut(dly)
   );

   // control and data path
   out_state_t state_q, state_d;
   logic [3:0] settle_q, settle_d;
   logic [2:0] phase_q, phase_d;
   logic [2:0] mode_q, mode_d; // {mirror, five, div}
   logic [SAMPLE_W-1:0] older_q, older_d;
   logic [SAMPLE_W-1:0] prim_q, prim_d, sec_q, sec_d;
   logic secAct_q, secAct_d;
   logic divPos_q, divPos_d;
   logic passThrough_q, passThrough_d;
   logic [2:0] divisor, lastPhase;
   logic modeHold, update;

   assign divisor = modeDivisor(mode_q[0], mode_q[1]);
   assign lastPhase = divisor - 3'h1;
   assign modeHold = (state_q == ST_RUN) && (selSync_q == mode_q);
   assign update = (phase_q == lastPhase);

   always_comb begin
      state_d = state_q;
      settle_d = settle_q;
      phase_d = phase_q;
      mode_d = mode_q;
      older_d = older_q;
      prim_d = prim_q;
      sec_d = sec_q;
      secAct_d = secAct_q;
      divPos_d = 1'b0;
      passThrough_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            mode_d = selSync_q;
            phase_d = PHASE_RESET;
            if (selSync_q != mode_q) begin
               settle_d = SETTLE_RESET;
            end else if (settle_q == 4'(MODE_SETTLE_CYCLES - 1)) begin
               state_d = ST_RUN;
            end else begin
               settle_d = settle_q + 4'h1;
            end
         end
         ST_RUN: begin
            if (selSync_q != mode_q) begin
               // a moved switch stops the stream until it settles again
               state_d = ST_IDLE;
               settle_d = SETTLE_RESET;
               prim_d = PORT_INACTIVE;
               sec_d = PORT_INACTIVE;
               secAct_d = 1'b0;
            end else begin
               phase_d = update ? PHASE_RESET : phase_q + 3'h1;
               // clock high for the first half of each output period that began with an update,
               // so the partial period right after locking gives no runt pulse
               divPos_d = mode_q[0] && (phase_d < 3'(divisor >> 1)) && (update || divPos_q);
               passThrough_d = !mode_q[0];
               secAct_d = mode_q[2] || (mode_q[0] && !mode_q[1]);
               if (phase_q == PHASE_RESET) begin
                  older_d = dly;
               end
               if (update) begin
                  prim_d = dly;
                  if (mode_q[2]) begin
                     sec_d = dly;
                  end else if (mode_q[0] && !mode_q[1]) begin
                     sec_d = older_d;
                  end else begin
                     sec_d = PORT_INACTIVE;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         settle_q <= SETTLE_RESET;
         phase_q <= PHASE_RESET;
         mode_q <= 3'h0;
         older_q <= SAMPLE_RESET;
         prim_q <= PORT_INACTIVE;
         sec_q <= PORT_INACTIVE;
         secAct_q <= 1'b0;
         divPos_q <= 1'b0;
         passThrough_q <= 1'b0;
      end else begin
         state_q <= state_d;
         settle_q <= settle_d;
         phase_q <= phase_d;
         mode_q <= mode_d;
         older_q <= older_d;
         prim_q <= prim_d;
         sec_q <= sec_d;
         secAct_q <= secAct_d;
         divPos_q <= divPos_d;
         passThrough_q <= passThrough_d;
      end
   end

   // half-cycle extension gives the odd divide its 50% duty
   logic divNeg_q, divNeg_d;

   always_comb begin
      divNeg_d = divPos_q && mode_q[1];
   end

   always_ff @(negedge sys_clk) begin
      if (rst) begin
         divNeg_q <= 1'b0;
      end else begin
         divNeg_q <= divNeg_d;
      end
   end

   // undivided mode forwards the sample clock itself
   assign outputDataClock = passThrough_q ? sys_clk : (divPos_q | divNeg_q);
   assign primaryOutputPort = prim_q;
   assign secondaryOutputPort = sec_q;
   assign secondaryActive = secAct_q;
   assign modeLocked = (state_q == ST_RUN);

   property p_full_primary;
      @(posedge sys_clk) disable iff (rst)
      modeHold && !mode_q[0] && !mode_q[2] |=> prim_q == $past(dly) && sec_q == PORT_INACTIVE;
   endproperty
   a_full_primary: assert property (p_full_primary) else $error("full-rate primary wrong");

   property p_full_mirror;
      @(posedge sys_clk) disable iff (rst)
      modeHold && !mode_q[0] && mode_q[2] |=> prim_q == $past(dly) && sec_q == prim_q;
   endproperty
   a_full_mirror: assert property (p_full_mirror) else $error("full-rate mirror wrong");

   property p_demux_pair;
      @(posedge sys_clk) disable iff (rst)
      modeHold && mode_q == 3'h1 && phase_q == 3'h0 ##1 modeHold
         |=> prim_q == $past(dly) && sec_q == $past(dly, 2);
   endproperty
   a_demux_pair: assert property (p_demux_pair) else $error("demux pair order wrong");

   property p_half_mirror_drop;
      @(posedge sys_clk) disable iff (rst)
      modeHold && mode_q == 3'h5 && phase_q == 3'h0 |=> $stable(prim_q) && prim_q == sec_q;
   endproperty
   a_half_mirror_drop: assert property (p_half_mirror_drop) else $error("mirror half rate wrong");

   property p_five_hold;
      @(posedge sys_clk) disable iff (rst)
      modeHold && mode_q[0] && mode_q[1] && phase_q != 3'h4 |=> $stable(prim_q) && $stable(sec_q);
   endproperty
   a_five_hold: assert property (p_five_hold) else $error("divide-by-five updated early");

   property p_five_update;
      @(posedge sys_clk) disable iff (rst)
      modeHold && mode_q == 3'h7 && phase_q == 3'h4 |=> prim_q == $past(dly) && sec_q == prim_q;
   endproperty
   a_five_update: assert property (p_five_update) else $error("divide-by-five mirror wrong");

   property p_five_inactive;
      @(posedge sys_clk) disable iff (rst)
      modeHold && mode_q == 3'h3 |=> sec_q == PORT_INACTIVE && !secAct_q;
   endproperty
   a_five_inactive: assert property (p_five_inactive) else $error("secondary not idle");

   property p_clk_half;
      @(posedge sys_clk) disable iff (rst)
      $rose(divPos_q) && mode_q[0] && !mode_q[1] && modeHold |=> !divPos_q ##1 divPos_q || !modeHold;
   endproperty
   a_clk_half: assert property (p_clk_half) else $error("divide-by-two clock duty wrong");

   property p_clk_five;
      @(posedge sys_clk) disable iff (rst)
      $rose(divPos_q) && mode_q[1] && modeHold ##1 modeHold |-> divPos_q ##1 !divPos_q [*3];
   endproperty
   a_clk_five: assert property (p_clk_five) else $error("divide-by-five clock shape wrong");

   property p_pass_clock;
      @(posedge sys_clk) disable iff (rst)
      modeHold && !mode_q[0] |=> passThrough_q;
   endproperty
   a_pass_clock: assert property (p_pass_clock) else $error("clock not passed through");

   property p_latency;
      @(posedge sys_clk) disable iff (rst)
      modeLocked |-> dly == $past(fallSample_q, LATENCY);
   endproperty
   a_latency: assert property (p_latency) else $error("pipeline latency wrong");

   property p_mode_static;
      @(posedge sys_clk) disable iff (rst)
      state_q == ST_RUN ##1 state_q == ST_RUN |-> $stable(mode_q);
   endproperty
   a_mode_static: assert property (p_mode_static) else $error("mode changed while running");

   c_demux: cover property (@(posedge sys_clk) disable iff (rst) modeHold && mode_q == 3'h1 && update);
   c_five_mirror: cover property (@(posedge sys_clk) disable iff (rst) modeHold && mode_q == 3'h7 && update);
   c_full_mirror: cover property (@(posedge sys_clk) disable iff (rst) modeHold && mode_q == 3'h4);
   c_relock: cover property (@(posedge sys_clk) disable iff (rst) $fell(modeLocked) ##[1:40] modeLocked);
endmodule

// file: core/adc_out_pkg.sv
// constants and types for the converter output stage
package adc_out_pkg;
   localparam int SAMPLE_W = 8;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int MODE_SETTLE_NS = 16;
   localparam int MODE_SETTLE_CYCLES = (MODE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PIPE_LATENCY_DEFAULT = 4;
   localparam logic [2:0] DIVISOR_ONE = 3'h1;
   localparam logic [2:0] DIVISOR_TWO = 3'h2;
   localparam logic [2:0] DIVISOR_FIVE = 3'h5;
   localparam logic [2:0] PHASE_RESET = 3'h0;
   localparam logic [3:0] SETTLE_RESET = 4'h0;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 8'h00;
   localparam logic [SAMPLE_W-1:0] PORT_INACTIVE = 8'h00;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } out_state_t;
endpackage

// file: core/sample_delay_line.sv
// fixed-length sample delay line
`timescale 1ns/1ps
module sample_delay_line import adc_out_pkg::*; #(
   parameter int WIDTH = SAMPLE_W,
   parameter int DEPTH = PIPE_LATENCY_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] dataIn,
   output logic [WIDTH-1:0] dataOut
);
   logic [WIDTH-1:0] stage_q [DEPTH];
   logic [WIDTH-1:0] stage_d [DEPTH];

   initial begin
      if (DEPTH < 1) begin
         $error("delay line needs at least one stage");
      end
   end

   always_comb begin
      stage_d[0] = dataIn;
      for (int i = 1; i < DEPTH; i++) begin
         stage_d[i] = stage_q[i-1];
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (rst) begin
            stage_q[i] <= '0;
         end else begin
            stage_q[i] <= stage_d[i];
         end
      end
   end

   assign dataOut = stage_q[DEPTH-1];
endmodule

// file: bench/capture_model.sv
// capture logic on the far side, registering both ports on the output data clock
`timescale 1ns/1ps
module capture_model import adc_out_pkg::*; (
   input wire logic outputDataClock,
   input wire logic [SAMPLE_W-1:0] primaryOutputPort,
   input wire logic [SAMPLE_W-1:0] secondaryOutputPort,
   output logic [SAMPLE_W-1:0] capPrim,
   output logic [SAMPLE_W-1:0] capSec,
   output logic [SAMPLE_W-1:0] prevPrim,
   output int capCount,
   output int periodPs,
   output int highPs
);
   realtime riseAt = 0.0;
   initial begin
      capPrim = 8'h00;
      capSec = 8'h00;
      prevPrim = 8'h00;
      capCount = 0;
      periodPs = 0;
      highPs = 0;
   end
   // data changes with the clock rise, so both ports are taken on its fall
   always @(negedge outputDataClock) begin
      prevPrim <= capPrim;
      capPrim <= primaryOutputPort;
      capSec <= secondaryOutputPort;
      capCount <= capCount + 1;
      highPs <= int'(($realtime - riseAt) * 1000.0);
   end
   always @(posedge outputDataClock) begin
      periodPs <= int'(($realtime - riseAt) * 1000.0);
      riseAt <= $realtime;
   end
endmodule

// file: bench/tb_adc_output_demux_decimator.sv
// self-checking bench for the converter output stage
`timescale 1ns/1ps
module tb_adc_output_demux_decimator import adc_out_pkg::*;;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic rateDivide = 1'b0;
   logic divideFiveSelect = 1'b0;
   logic mirrorOutputs = 1'b0;
   logic [SAMPLE_W-1:0] sampleIn = 8'h00;
   logic [SAMPLE_W-1:0] primaryOutputPort, secondaryOutputPort, capPrim, capSec, prevPrim;
   logic outputDataClock, secondaryActive, modeLocked;
   int capCount, periodPs, highPs;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   localparam int PIPE_DEPTH = 3;

   adc_output_demux_decimator #(.LATENCY(PIPE_DEPTH)) i_adc_output_demux_decimator (.sys_clk(sys_clk), .rst(rst),
      .sampleIn(sampleIn), .rateDivide(rateDivide), .divideFiveSelect(divideFiveSelect),
      .mirrorOutputs(mirrorOutputs), .primaryOutputPort(primaryOutputPort),
      .secondaryOutputPort(secondaryOutputPort), .outputDataClock(outputDataClock),
      .secondaryActive(secondaryActive), .modeLocked(modeLocked));
   capture_model i_capture_model (.outputDataClock(outputDataClock), .primaryOutputPort(primaryOutputPort),
      .secondaryOutputPort(secondaryOutputPort), .capPrim(capPrim), .capSec(capSec), .prevPrim(prevPrim),
      .capCount(capCount), .periodPs(periodPs), .highPs(highPs));

   always #2 sys_clk = ~sys_clk;
   // a counting stream makes every sample identifiable
   always @(negedge sys_clk) sampleIn <= sampleIn + 8'h01;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_cap();
      int c0;
      c0 = capCount;
      // falling sys_clk edges: captures and design outputs have settled by then
      for (int i = 0; i < 30 && capCount == c0; i++) @(negedge sys_clk);
      check({31'h0, capCount != c0}, 32'h1);
   endtask

   task automatic wait_lock(input logic level);
      for (int i = 0; i < 40 && modeLocked !== level; i++) @(negedge sys_clk);
      check({31'h0, modeLocked}, {31'h0, level});
   endtask

   task automatic run_mode(input logic d, input logic f, input logic m, input int div);
      logic [SAMPLE_W-1:0] expSec;
      @(negedge sys_clk);
      rst <= 1'b1;
      rateDivide <= d;
      divideFiveSelect <= f;
      mirrorOutputs <= m;
      repeat (16) @(negedge sys_clk);
      check({24'h0, primaryOutputPort}, {24'h0, PORT_INACTIVE});
      check({31'h0, modeLocked}, 32'h0);
      rst <= 1'b0;
      wait_lock(1'b1);
      repeat (3) wait_cap();
      repeat (4) begin
         wait_cap();
         check({24'h0, capPrim - prevPrim}, div);
         expSec = m ? capPrim : (div == 2 ? capPrim - 8'h01 : PORT_INACTIVE);
         check({24'h0, capSec}, {24'h0, expSec});
         check({31'h0, secondaryActive}, {31'h0, m || div == 2});
         check(periodPs, 4000 * div);
         check(highPs, 2000 * div);
         // full rate: falling-edge capture plus the pipeline stages plus the port register
         if (div == 1) begin
            check({24'h0, sampleIn - primaryOutputPort}, PIPE_DEPTH + 1);
         end
      end
   endtask

   task automatic test_full_single(); run_mode(1'b0, 1'b0, 1'b0, 1); endtask
   task automatic test_full_mirror(); run_mode(1'b0, 1'b0, 1'b1, 1); endtask
   task automatic test_five_ignored(); run_mode(1'b0, 1'b1, 1'b0, 1); endtask
   task automatic test_demux(); run_mode(1'b1, 1'b0, 1'b0, 2); endtask
   task automatic test_half_mirror(); run_mode(1'b1, 1'b0, 1'b1, 2); endtask
   task automatic test_fifth(); run_mode(1'b1, 1'b1, 1'b0, 5); endtask
   task automatic test_fifth_mirror(); run_mode(1'b1, 1'b1, 1'b1, 5); endtask

   // switch flipped while running: the stage drops to idle, clears ports and relocks
   task automatic test_mode_change();
      run_mode(1'b1, 1'b0, 1'b0, 2);
      mirrorOutputs <= 1'b1;
      wait_lock(1'b0);
      check({24'h0, primaryOutputPort}, {24'h0, PORT_INACTIVE});
      wait_lock(1'b1);
      repeat (3) wait_cap();
      wait_cap();
      check({24'h0, capSec}, {24'h0, capPrim});
      check({24'h0, capPrim - prevPrim}, 32'h2);
   endtask

   initial begin
      test_full_single();
      test_full_mirror();
      test_five_ignored();
      test_demux();
      test_half_mirror();
      test_fifth();
      test_fifth_mirror();
      test_mode_change();
      wrap_up();
   end
endmodule
